// ### logic/cbb_defs.svh
// Purpose: Offsets, field positions and reset values of the bridge window registers.
// Assumes: Register addresses are byte offsets on the plain register port.
// Notes:   Definitions only; included by bare name.
`ifndef CBB_DEFS_SVH
`define CBB_DEFS_SVH

`define CBB_OFF_PRI    8'h18
`define CBB_OFF_SEC    8'h19
`define CBB_OFF_SUB    8'h1A
`define CBB_OFF_LAT    8'h1B
`define CBB_OFF_BASE0  8'h1C
`define CBB_OFF_LIM0   8'h20
`define CBB_OFF_BASE1  8'h24
`define CBB_OFF_LIM1   8'h28
`define CBB_OFF_BCTL   8'h3E
`define CBB_OFF_STAT   8'h40

`define CBB_RST_BUS    8'h00
`define CBB_RST_LAT    8'h00
`define CBB_RST_PAGE   20'h0_0000
`define CBB_RST_PF     1'h0

`define CBB_PAGE_LSB   12
`define CBB_BCTL_PF0   8
`define CBB_BCTL_PF1   9
`define CBB_STAT_LAST  8

`endif

// ### logic/cbb_pkg.sv
// Purpose: Shared types of the bridge window block.
// Assumes: Nothing beyond the defines header.
// Notes:   Used only through scoped names.
package cbb_pkg;

    // Latency timer states, one-hot.
    typedef enum logic [2:0]
    {
        CBB_LAT_IDLE  = 3'h1,
        CBB_LAT_COUNT = 3'h2,
        CBB_LAT_LAST  = 3'h4
    } cbb_lat_state_t;

endpackage

// ### logic/cbb_lat_timer.sv
// Purpose: CardBus initiator latency timer for one controller function.
// Assumes: The clock is the CardBus clock; inputs come from logic on the same clock.
// Notes:   The transaction engine reads last_phase to end at the next data phase.
`timescale 1ns/10ps
module cbb_lat_timer
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [7:0] limit,
    input  wire logic       frame_start,
    input  wire logic       phase_done,
    input  wire logic       txn_done,
    output logic            last_phase,
    output logic [7:0]      count
);

    cbb_pkg::cbb_lat_state_t state;
    cbb_pkg::cbb_lat_state_t next_state;
    logic [7:0]              next_count;

    // Next state; a limit of zero expires at once, so the first phase is the last.
    always_comb
    begin
        next_state = state;
        next_count = count;
        unique case (state)
            cbb_pkg::CBB_LAT_IDLE:
            begin
                if (frame_start)
                begin
                    next_count = limit;
                    next_state = (limit == 8'h00) ? cbb_pkg::CBB_LAT_LAST
                                                  : cbb_pkg::CBB_LAT_COUNT;
                end
            end
            cbb_pkg::CBB_LAT_COUNT:
            begin
                next_count = count - 8'h01;
                if (txn_done)
                    next_state = cbb_pkg::CBB_LAT_IDLE;
                else if (count == 8'h01)
                    next_state = cbb_pkg::CBB_LAT_LAST;
            end
            cbb_pkg::CBB_LAT_LAST:
            begin
                next_count = 8'h00;
                if (phase_done || txn_done)
                    next_state = cbb_pkg::CBB_LAT_IDLE;
            end
            default:
            begin
                next_state = cbb_pkg::CBB_LAT_IDLE;
                next_count = 8'h00;
            end
        endcase
    end

    // State registers.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= cbb_pkg::CBB_LAT_IDLE;
            count <= 8'h00;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
        end
    end

    assign last_phase = (state == cbb_pkg::CBB_LAT_LAST);

    default clocking lat_cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence lat_start_s;
        (state == cbb_pkg::CBB_LAT_IDLE) && frame_start && (limit == 8'h03);
    endsequence

    // A limit of three expires exactly four clocks after the frame starts.
    lat_expire_a: assert property (lat_start_s ##1 !txn_done [*3] |=> last_phase)
        else $error("latency timer did not expire after three clocks");
    lat_early_a: assert property (lat_start_s |=> !last_phase [*2])
        else $error("latency timer expired early");
    last_stop_a: assert property (last_phase && phase_done |=> !last_phase)
        else $error("transaction not ended after the data phase");
    last_hold_a: assert property (last_phase && !phase_done && !txn_done
        |=> last_phase)
        else $error("last phase dropped before the data phase ended");

endmodule

// ### logic/cbb_top.sv
// Purpose: Bus number, latency and memory base registers of a CardBus bridge.
// Assumes: One clock that is also the CardBus clock; all inputs share it.
// Notes:   Every controller function has its own register copy, picked by reg_func.
//
// Functional notes
// - Secondary bus number register, 19h, resets zero.
// - Subordinate bus number register, 1Ah, resets zero.
// - Bus numbers decide configuration cycle forwarding.
// - Each function keeps its own bus numbers.
// - Latency limit register, 1Bh, in clocks.
// - Latency count starts with the frame.
// - Expired count ends after next data phase.
// - Memory base sets lower window bound.
// - Base bits 31 to 12 are writable.
// - Base bits 11 to 0 read zero.
// - Control bits 8, 9 mark prefetchable windows.
// - Zero base and limit disables window.
// - Primary bus number register, 18h, resets zero.
`timescale 1ns/10ps
`include "cbb_defs.svh"
module cbb_top
#(
    parameter  int NUM_FUNC = 2,
    localparam int FW       = (NUM_FUNC > 1) ? $clog2(NUM_FUNC) : 1
)
(
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [FW-1:0]       reg_func,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [31:0]         reg_rdata,
    input  wire logic                cfg_valid,
    input  wire logic                cfg_type1,
    input  wire logic [7:0]          cfg_bus,
    output logic      [NUM_FUNC-1:0] cfg_to_type0,
    output logic      [NUM_FUNC-1:0] cfg_to_type1,
    input  wire logic                mem_valid,
    input  wire logic                mem_from_cb,
    input  wire logic [31:0]         mem_addr,
    output logic      [NUM_FUNC-1:0] mem_claim,
    output logic      [NUM_FUNC-1:0] mem_window,
    output logic      [NUM_FUNC-1:0] mem_prefetch,
    output logic      [NUM_FUNC-1:0] mem_to_pci,
    input  wire logic [NUM_FUNC-1:0] cb_frame_start,
    input  wire logic [NUM_FUNC-1:0] cb_phase_done,
    input  wire logic [NUM_FUNC-1:0] cb_txn_done,
    output logic      [NUM_FUNC-1:0] cb_last_phase
);

    if (NUM_FUNC < 1 || NUM_FUNC > 4)
    begin : g_bad_func
        $error("NUM_FUNC must lie between 1 and 4");
    end

    // Register address match, used by the write decoder and the assertions.
    function automatic logic reg_sel(input logic [7:0] a, input logic [7:0] off);
        reg_sel = (a == off);
    endfunction

    // Window match on 4-Kbyte pages; an all-zero window never matches.
    function automatic logic win_hit(input logic [19:0] base,
                                     input logic [19:0] lim,
                                     input logic [31:0] a);
        win_hit = ((base != `CBB_RST_PAGE) || (lim != `CBB_RST_PAGE))
                  && (a[31:`CBB_PAGE_LSB] >= base)
                  && (a[31:`CBB_PAGE_LSB] <= lim);
    endfunction

    logic [7:0]  pri_bus [NUM_FUNC];
    logic [7:0]  sec_bus [NUM_FUNC];
    logic [7:0]  sub_bus [NUM_FUNC];
    logic [7:0]  lat_lim [NUM_FUNC];
    logic [19:0] base0   [NUM_FUNC];
    logic [19:0] lim0    [NUM_FUNC];
    logic [19:0] base1   [NUM_FUNC];
    logic [19:0] lim1    [NUM_FUNC];
    logic        pf0     [NUM_FUNC];
    logic        pf1     [NUM_FUNC];
    logic [7:0]  next_pri_bus [NUM_FUNC];
    logic [7:0]  next_sec_bus [NUM_FUNC];
    logic [7:0]  next_sub_bus [NUM_FUNC];
    logic [7:0]  next_lat_lim [NUM_FUNC];
    logic [19:0] next_base0   [NUM_FUNC];
    logic [19:0] next_lim0    [NUM_FUNC];
    logic [19:0] next_base1   [NUM_FUNC];
    logic [19:0] next_lim1    [NUM_FUNC];
    logic        next_pf0     [NUM_FUNC];
    logic        next_pf1     [NUM_FUNC];
    logic [7:0]  lat_count    [NUM_FUNC];

    // Register writes; only the copy of the addressed function changes.
    always_comb
    begin
        for (int f = 0; f < NUM_FUNC; f++)
        begin
            next_pri_bus[f] = pri_bus[f];
            next_sec_bus[f] = sec_bus[f];
            next_sub_bus[f] = sub_bus[f];
            next_lat_lim[f] = lat_lim[f];
            next_base0[f]   = base0[f];
            next_lim0[f]    = lim0[f];
            next_base1[f]   = base1[f];
            next_lim1[f]    = lim1[f];
            next_pf0[f]     = pf0[f];
            next_pf1[f]     = pf1[f];
            if (reg_wr && (reg_func == FW'(f)))
            begin
                if (reg_sel(reg_addr, `CBB_OFF_PRI))
                    next_pri_bus[f] = reg_wdata[7:0];
                if (reg_sel(reg_addr, `CBB_OFF_SEC))
                    next_sec_bus[f] = reg_wdata[7:0];
                if (reg_sel(reg_addr, `CBB_OFF_SUB))
                    next_sub_bus[f] = reg_wdata[7:0];
                if (reg_sel(reg_addr, `CBB_OFF_LAT))
                    next_lat_lim[f] = reg_wdata[7:0];
                // The low twelve bits of the word are simply dropped.
                if (reg_sel(reg_addr, `CBB_OFF_BASE0))
                    next_base0[f] = reg_wdata[31:`CBB_PAGE_LSB];
                if (reg_sel(reg_addr, `CBB_OFF_LIM0))
                    next_lim0[f] = reg_wdata[31:`CBB_PAGE_LSB];
                if (reg_sel(reg_addr, `CBB_OFF_BASE1))
                    next_base1[f] = reg_wdata[31:`CBB_PAGE_LSB];
                if (reg_sel(reg_addr, `CBB_OFF_LIM1))
                    next_lim1[f] = reg_wdata[31:`CBB_PAGE_LSB];
                if (reg_sel(reg_addr, `CBB_OFF_BCTL))
                begin
                    next_pf0[f] = reg_wdata[`CBB_BCTL_PF0];
                    next_pf1[f] = reg_wdata[`CBB_BCTL_PF1];
                end
            end
        end
    end

    // Register storage.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int f = 0; f < NUM_FUNC; f++)
            begin
                pri_bus[f] <= `CBB_RST_BUS;
                sec_bus[f] <= `CBB_RST_BUS;
                sub_bus[f] <= `CBB_RST_BUS;
                lat_lim[f] <= `CBB_RST_LAT;
                base0[f]   <= `CBB_RST_PAGE;
                lim0[f]    <= `CBB_RST_PAGE;
                base1[f]   <= `CBB_RST_PAGE;
                lim1[f]    <= `CBB_RST_PAGE;
                pf0[f]     <= `CBB_RST_PF;
                pf1[f]     <= `CBB_RST_PF;
            end
        end
        else
        begin
            for (int f = 0; f < NUM_FUNC; f++)
            begin
                pri_bus[f] <= next_pri_bus[f];
                sec_bus[f] <= next_sec_bus[f];
                sub_bus[f] <= next_sub_bus[f];
                lat_lim[f] <= next_lat_lim[f];
                base0[f]   <= next_base0[f];
                lim0[f]    <= next_lim0[f];
                base1[f]   <= next_base1[f];
                lim1[f]    <= next_lim1[f];
                pf0[f]     <= next_pf0[f];
                pf1[f]     <= next_pf1[f];
            end
        end
    end

    logic [31:0] next_rdata;
    int          fs;

    // Read mux; a function number beyond the last one, or a hole, reads zero.
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        fs         = int'(reg_func);
        if (reg_rd && (fs < NUM_FUNC))
        begin
            unique case (reg_addr)
                `CBB_OFF_PRI:   next_rdata[7:0] = pri_bus[fs];
                `CBB_OFF_SEC:   next_rdata[7:0] = sec_bus[fs];
                `CBB_OFF_SUB:   next_rdata[7:0] = sub_bus[fs];
                `CBB_OFF_LAT:   next_rdata[7:0] = lat_lim[fs];
                `CBB_OFF_BASE0: next_rdata = {base0[fs], 12'h000};
                `CBB_OFF_LIM0:  next_rdata = {lim0[fs], 12'h000};
                `CBB_OFF_BASE1: next_rdata = {base1[fs], 12'h000};
                `CBB_OFF_LIM1:  next_rdata = {lim1[fs], 12'h000};
                `CBB_OFF_BCTL:
                begin
                    next_rdata[`CBB_BCTL_PF0] = pf0[fs];
                    next_rdata[`CBB_BCTL_PF1] = pf1[fs];
                end
                `CBB_OFF_STAT:
                begin
                    next_rdata[7:0]            = lat_count[fs];
                    next_rdata[`CBB_STAT_LAST] = cb_last_phase[fs];
                end
                default:        next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0000_0000;
        else
            reg_rdata <= next_rdata;
    end

    logic [NUM_FUNC-1:0] next_to_type0;
    logic [NUM_FUNC-1:0] next_to_type1;
    logic [NUM_FUNC-1:0] next_claim;
    logic [NUM_FUNC-1:0] next_window;
    logic [NUM_FUNC-1:0] next_prefetch;
    logic [NUM_FUNC-1:0] next_to_pci;
    logic                h0;
    logic                h1;

    // Forwarding decisions. A cycle naming the primary bus is never passed down,
    // which keeps a misprogrammed secondary number from shadowing the own bus.
    always_comb
    begin
        for (int f = 0; f < NUM_FUNC; f++)
        begin
            next_to_type0[f] = cfg_valid && cfg_type1 && (cfg_bus != pri_bus[f])
                               && (cfg_bus == sec_bus[f]);
            next_to_type1[f] = cfg_valid && cfg_type1 && (cfg_bus != pri_bus[f])
                               && (cfg_bus > sec_bus[f])
                               && (cfg_bus <= sub_bus[f]);
            h0 = win_hit(base0[f], lim0[f], mem_addr);
            h1 = win_hit(base1[f], lim1[f], mem_addr);
            // Window 0 wins where the two overlap.
            next_claim[f]    = mem_valid && !mem_from_cb && (h0 || h1);
            next_window[f]   = !h0 && h1;
            next_prefetch[f] = h0 ? pf0[f] : (h1 && pf1[f]);
            next_to_pci[f]   = mem_valid && mem_from_cb && !h0 && !h1;
        end
    end

    // Decision outputs, one clock after the request.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_to_type0 <= '0;
            cfg_to_type1 <= '0;
            mem_claim    <= '0;
            mem_window   <= '0;
            mem_prefetch <= '0;
            mem_to_pci   <= '0;
        end
        else
        begin
            cfg_to_type0 <= next_to_type0;
            cfg_to_type1 <= next_to_type1;
            mem_claim    <= next_claim;
            mem_window   <= next_window;
            mem_prefetch <= next_claim & next_prefetch;
            mem_to_pci   <= next_to_pci;
        end
    end

    // One latency timer for each function; the host is expected to keep the limit
    // at 40h or above, otherwise bursts get cut short.
    for (genvar g = 0; g < NUM_FUNC; g++)
    begin : g_lat
        cbb_lat_timer u_lat
        (
            .clock       (clock),
            .rst_n       (rst_n),
            .limit       (lat_lim[g]),
            .frame_start (cb_frame_start[g]),
            .phase_done  (cb_phase_done[g]),
            .txn_done    (cb_txn_done[g]),
            .last_phase  (cb_last_phase[g]),
            .count       (lat_count[g])
        );
    end

    logic [7:0]  sec0;
    logic [19:0] b0;
    logic [19:0] l0;
    assign sec0 = sec_bus[0];
    assign b0   = base0[0];
    assign l0   = lim0[0];

    default clocking top_cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence wr_sub_s;
        reg_wr && reg_sel(reg_addr, `CBB_OFF_SUB) && (reg_func == '0);
    endsequence
    sequence rd_sub_s;
        reg_rd && reg_sel(reg_addr, `CBB_OFF_SUB) && (reg_func == '0);
    endsequence

    sub_round_a: assert property (wr_sub_s ##1 !reg_wr ##1 rd_sub_s |=>
        reg_rdata == {24'h00_0000, $past(reg_wdata[7:0], 3)})
        else $error("subordinate number not read back");
    sec_read_a: assert property (reg_rd && reg_sel(reg_addr, `CBB_OFF_SEC)
        && (reg_func == '0) |=> reg_rdata == {24'h00_0000, $past(sec0)})
        else $error("secondary number read wrong");
    base_low_a: assert property (reg_rd && reg_sel(reg_addr, `CBB_OFF_BASE0)
        |=> reg_rdata[11:0] == 12'h000)
        else $error("memory base low bits not zero");
    base_write_a: assert property (reg_wr && reg_sel(reg_addr, `CBB_OFF_BASE0)
        && (reg_func == '0) |=> b0 == $past(reg_wdata[31:12]))
        else $error("memory base upper bits not stored");
    win_off_a: assert property (mem_valid && (base0[NUM_FUNC-1] == 20'h0_0000)
        && (lim0[NUM_FUNC-1] == 20'h0_0000)
        && !win_hit(base1[NUM_FUNC-1], lim1[NUM_FUNC-1], mem_addr)
        |=> !mem_claim[NUM_FUNC-1])
        else $error("claim through a disabled window");
    win_claim_a: assert property (mem_valid && !mem_from_cb && (l0 != 20'h0_0000)
        && (mem_addr[31:12] >= b0) && (mem_addr[31:12] <= l0)
        |=> mem_claim[0] && !mem_window[0])
        else $error("address inside window 0 not claimed");
    cfg_zero_a: assert property (cfg_valid && cfg_type1 && (cfg_bus == sec0)
        && (cfg_bus != pri_bus[0]) |=> cfg_to_type0[0] && !cfg_to_type1[0])
        else $error("secondary target not turned to type 0");
    cfg_pass_a: assert property (cfg_to_type1[0] |-> !cfg_to_type0[0]
        && ($past(cfg_bus) > $past(sec0)))
        else $error("type 1 pass without a bus above secondary");

endmodule

// ### sim/cbb_card_model.sv
// Purpose: Card side stand-in that runs CardBus transactions for one function.
// Assumes: Same clock as the bridge; start and abort are one-cycle pulses.
// Notes:   A transaction ends at a data phase while last_phase is high, or on abort.
`timescale 1ns/10ps
module cbb_card_model
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic [3:0] gap,
    input  wire logic       last_phase,
    output logic            frame_start,
    output logic            phase_done,
    output logic            txn_done,
    output logic            busy
);
    logic [3:0] cnt;

    // One data phase every gap+1 clocks, so a large gap plays a slow target.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy        <= 1'b0;
            frame_start <= 1'b0;
            phase_done  <= 1'b0;
            txn_done    <= 1'b0;
            cnt         <= 4'h0;
        end
        else
        begin
            frame_start <= start && !busy;
            phase_done  <= 1'b0;
            txn_done    <= 1'b0;
            if (start && !busy)
            begin
                busy <= 1'b1;
                cnt  <= 4'h0;
            end
            else if (busy && abort)
            begin
                busy     <= 1'b0;
                txn_done <= 1'b1;
            end
            else if (busy)
            begin
                cnt <= cnt + 4'h1;
                if (cnt == gap)
                begin
                    phase_done <= 1'b1;
                    cnt        <= 4'h0;
                    busy       <= !last_phase;
                end
            end
        end
    end
endmodule

// ### sim/tb.sv
// Purpose: Self-checking bench for the bridge window registers.
// Assumes: Two functions; the card model drives the function 0 timer.
// Notes:   Expected values are worked out here, never read back from outputs.
`timescale 1ns/10ps
module tb;
    localparam logic [7:0]  PRI      = 8'h01;
    localparam logic [7:0]  SEC [2]  = '{8'h05, 8'h0A};
    localparam logic [7:0]  SUB [2]  = '{8'h08, 8'h0C};
    localparam logic [7:0]  OFFS [11] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h20,
                                          8'h24, 8'h28, 8'h3E, 8'h40, 8'h30};
    localparam logic [31:0] ADDRS [8] = '{32'h0000_0000, 32'h0000_FFFF, 32'h0001_0000,
        32'h0001_FFFF, 32'h0002_0000, 32'h0007_FFFF, 32'h0008_0FFF, 32'h0008_1000};
    logic        clock, rst_n, reg_func, reg_wr, reg_rd;
    logic [7:0]  reg_addr, cfg_bus;
    logic [31:0] reg_wdata, reg_rdata, mem_addr;
    logic        cfg_valid, cfg_type1, mem_valid, mem_from_cb;
    logic [1:0]  to0, to1, claim, win, pf, to_pci, last;
    logic        start, abort, fs, pd, td, busy;
    logic [3:0]  gap;
    int          fails, n_compared;

    // The bridge under test, function 1 timer left idle.
    cbb_top #(.NUM_FUNC(2)) uut
    (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_func(reg_func),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cfg_valid(cfg_valid), .cfg_type1(cfg_type1), .cfg_bus(cfg_bus),
        .cfg_to_type0(to0), .cfg_to_type1(to1), .mem_valid(mem_valid),
        .mem_from_cb(mem_from_cb), .mem_addr(mem_addr), .mem_claim(claim),
        .mem_window(win), .mem_prefetch(pf), .mem_to_pci(to_pci),
        .cb_frame_start({1'b0, fs}), .cb_phase_done({1'b0, pd}),
        .cb_txn_done({1'b0, td}), .cb_last_phase(last)
    );

    // Card side of function 0.
    cbb_card_model card
    (
        .clock(clock), .rst_n(rst_n), .start(start), .abort(abort), .gap(gap),
        .last_phase(last[0]), .frame_start(fs), .phase_done(pd), .txn_done(td),
        .busy(busy)
    );

    // Free-running 25 MHz clock.
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Single-cycle write; the strobe drops at the next edge.
    task automatic wr(input logic f, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_func  <= f;
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Read data are only valid in the cycle after the strobe, so sample there.
    task automatic rdc(input logic f, input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge clock);
        reg_func <= f;
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(n, reg_rdata, e);
    endtask

    task automatic t_reset;
        for (int f = 0; f < 2; f++)
            for (int i = 0; i < 11; i++)
                rdc(f[0], OFFS[i], 32'h0000_0000, "reset value");
        wr(1'b0, 8'h30, 32'hFFFF_FFFF);
        rdc(1'b0, 8'h30, 32'h0000_0000, "unmapped");
    endtask

    task automatic t_regs;
        for (int f = 0; f < 2; f++)
        begin
            wr(f[0], 8'h18, {24'h00_0000, PRI});
            wr(f[0], 8'h19, {24'h00_0000, SEC[f]});
            wr(f[0], 8'h1A, {24'h00_0000, SUB[f]});
        end
        wr(1'b0, 8'h1B, 32'hFFFF_FFA5);
        wr(1'b0, 8'h1A, {24'h00_0000, SUB[0]});
        rdc(1'b0, 8'h1A, 32'h0000_0008, "subordinate f0");
        rdc(1'b0, 8'h18, 32'h0000_0001, "primary");
        rdc(1'b0, 8'h19, 32'h0000_0005, "secondary f0");
        rdc(1'b1, 8'h19, 32'h0000_000A, "secondary f1");
        rdc(1'b1, 8'h1A, 32'h0000_000C, "subordinate");
        rdc(1'b0, 8'h1B, 32'h0000_00A5, "latency f0");
        rdc(1'b1, 8'h1B, 32'h0000_0000, "latency f1");
    endtask

    // Every bus number 0..15 as type 0 and type 1 against both functions.
    task automatic t_cfg;
        logic [1:0] e0;
        logic [1:0] e1;
        for (int b = 0; b < 16; b++)
            for (int t = 0; t < 2; t++)
            begin
                for (int f = 0; f < 2; f++)
                begin
                    e0[f] = t == 1 && b == SEC[f] && b != PRI;
                    e1[f] = t == 1 && b > SEC[f] && b <= SUB[f] && b != PRI;
                end
                @(posedge clock);
                cfg_valid <= 1'b1;
                cfg_type1 <= t[0];
                cfg_bus   <= b[7:0];
                @(posedge clock);
                #1 chk("to type 0", 32'(to0), 32'(e0));
                chk("to type 1", 32'(to1), 32'(e1));
            end
        @(posedge clock);
        cfg_valid <= 1'b0;
    endtask

    // Function 0 gets two windows, function 1 keeps both windows at zero.
    task automatic t_mem;
        logic [19:0] pg;
        logic        h0, h1;
        logic [1:0]  ec, ew, et;
        wr(1'b0, 8'h1C, 32'hFFFF_FFFF);
        rdc(1'b0, 8'h1C, 32'hFFFF_F000, "base bits");
        wr(1'b0, 8'h1C, 32'h0001_0ABC);
        wr(1'b0, 8'h20, 32'h0001_F000);
        wr(1'b0, 8'h24, 32'h0008_0000);
        wr(1'b0, 8'h28, 32'h0008_0000);
        wr(1'b0, 8'h3E, 32'hFFFF_FFFF);
        rdc(1'b0, 8'h3E, 32'h0000_0300, "bridge control");
        wr(1'b0, 8'h3E, 32'h0000_0200);
        rdc(1'b0, 8'h1C, 32'h0001_0000, "base low zero");
        for (int i = 0; i < 8; i++)
            for (int cb = 0; cb < 2; cb++)
            begin
                pg = ADDRS[i][31:12];
                h0 = pg >= 20'h0_0010 && pg <= 20'h0_001F;
                h1 = pg == 20'h0_0080;
                ec = {1'b0, cb == 0 && (h0 || h1)};
                ew = {1'b0, ec[0] && !h0};
                et = {cb[0], cb == 1 && !(h0 || h1)};
                @(posedge clock);
                mem_valid   <= 1'b1;
                mem_from_cb <= cb[0];
                mem_addr    <= ADDRS[i];
                @(posedge clock);
                #1 chk("claim", 32'(claim), 32'(ec));
                chk("window", 32'(win & ec), 32'(ew));
                chk("prefetch", 32'(pf), 32'(ew));
                chk("to pci", 32'(to_pci), 32'(et));
            end
        @(posedge clock);
        mem_valid <= 1'b0;
    endtask

    // Expiry must land limit+1 edges after the frame, then hold to the next phase.
    task automatic t_lat(input logic [7:0] lim);
        int n;
        wr(1'b0, 8'h1B, {24'h00_0000, lim});
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clock);
            #1 n++;
        end while (last[0] !== 1'b1 && n < 100);
        chk("expiry delay", n, lim + 1);
        if (n >= 100)
            final_report;
        n = 0;
        while (pd !== 1'b1 && n < 40)
        begin
            @(posedge clock);
            #1 n++;
        end
        chk("phase wait", 32'(n < 40), 32'h0000_0001);
        if (n >= 40)
            final_report;
        chk("held to phase", 32'(last[0]), 32'h0000_0001);
        @(posedge clock);
        #1 chk("drop after phase", 32'(last), 32'h0000_0000);
        chk("transaction over", 32'(busy), 32'h0000_0000);
    endtask

    // An abort before expiry must cancel the count for good.
    task automatic t_abort;
        wr(1'b0, 8'h1B, 32'h0000_000A);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        repeat (3) @(posedge clock);
        rdc(1'b0, 8'h40, 32'h0000_0007, "count running");
        abort <= 1'b1;
        @(posedge clock);
        abort <= 1'b0;
        repeat (20)
        begin
            @(posedge clock);
            #1 chk("cancelled", 32'(last), 32'h0000_0000);
        end
    endtask

    // Main sequence; the 40h case is the smallest value a host should program.
    initial
    begin
        rst_n       = 1'b0;
        reg_func    = 1'b0;
        reg_addr    = 8'h00;
        reg_wdata   = 32'h0000_0000;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        cfg_valid   = 1'b0;
        cfg_type1   = 1'b0;
        cfg_bus     = 8'h00;
        mem_valid   = 1'b0;
        mem_from_cb = 1'b0;
        mem_addr    = 32'h0000_0000;
        start       = 1'b0;
        abort       = 1'b0;
        gap         = 4'hF;
        fails       = 0;
        n_compared  = 0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        t_reset;
        t_regs;
        t_cfg;
        t_mem;
        t_lat(8'h00);
        t_lat(8'h05);
        t_lat(8'h03);
        t_lat(8'h40);
        t_abort;
        final_report;
    end
endmodule
